// ===== ee_pkg.sv
// package: constants and carrier types for the two-wire eeprom slave
`default_nettype none
package ee_pkg;

    // ------------------------------------------------------------
    // geometry of the array and the page buffer
    // ------------------------------------------------------------
    localparam int ADDR_W = 11;
    localparam int MEM_BYTES = 2048;
    localparam int PAGE_W = 4;
    localparam int PAGE_BYTES = 16;
    localparam logic [10:0] RST_PTR = 11'h000;
    localparam logic [15:0] RST_VALID = 16'h0000;

    // ------------------------------------------------------------
    // control byte layout
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_CODE = 4'ha;
    localparam int CODE_MSB = 7;
    localparam int CODE_LSB = 4;
    localparam int BLK_MSB = 3;
    localparam int BLK_LSB = 1;
    localparam int DIR_BIT = 0;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // ------------------------------------------------------------
    // self-timed write cycle
    // ------------------------------------------------------------
    localparam int T_WC_MS = 5;
    localparam int CLK_MHZ = 250;
    localparam int WC_CYCLES = T_WC_MS * CLK_MHZ * 1000;
    localparam int TIMER_W = 21;

    // protocol states, gray along idle-rx-ack-tx-ack
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RX = 3'h1,
        ST_RXACK = 3'h3,
        ST_TX = 3'h2,
        ST_TXACK = 3'h6
    } ee_state_e;

    // meaning of the byte being moved
    typedef enum logic [1:0] {
        K_CTRL = 2'h0,
        K_ADDR = 2'h1,
        K_WDATA = 2'h3,
        K_RDATA = 2'h2
    } ee_kind_e;

    // pin levels
    typedef struct packed {
        logic scl;
        logic sda;
        logic wp;
    } ee_pins_s;

    // bus events seen by the clock domain
    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } ee_edges_s;

endpackage
`default_nettype wire

// ===== ee_sync.sv
// module: pin synchroniser and bus condition detector
`timescale 1ns/1ns
`default_nettype none
module ee_sync (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire ee_pkg::ee_pins_s pins_i,
    output var ee_pkg::ee_pins_s pins_o,
    output var ee_pkg::ee_edges_s edges_o
);

    // ------------------------------------------------------------
    // two-flop synchroniser plus one history stage
    // ------------------------------------------------------------
    ee_pkg::ee_pins_s meta;
    ee_pkg::ee_pins_s stage;
    ee_pkg::ee_pins_s prev;
    ee_pkg::ee_pins_s next_meta;
    ee_pkg::ee_pins_s next_stage;
    ee_pkg::ee_pins_s next_prev;

    // idle bus reads high on both lines
    always_comb begin
        next_meta = pins_i;
        next_stage = meta;
        next_prev = stage;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            meta <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0};
            stage <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0};
            prev <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0};
        end else begin
            meta <= next_meta;
            stage <= next_stage;
            prev <= next_prev;
        end
    end

    // edges only look at the settled stages, never at meta
    always_comb begin
        pins_o = stage;
        edges_o.scl_rise = stage.scl && !prev.scl;
        edges_o.scl_fall = !stage.scl && prev.scl;
        edges_o.start = stage.scl && prev.scl && prev.sda && !stage.sda;
        edges_o.stop = stage.scl && prev.scl && !prev.sda && stage.sda;
    end

endmodule
`default_nettype wire

// ===== ee_slave.sv
// module: two-wire serial eeprom slave, protocol engine, page buffer and array
`timescale 1ns/1ns
`default_nettype none
module ee_slave #(
    parameter int unsigned WRITE_CYCLES = ee_pkg::WC_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic wp_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    output logic write_busy_o
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam logic [20:0] T_LAST = 21'(WRITE_CYCLES - 1);

    ee_pkg::ee_pins_s pin;
    ee_pkg::ee_edges_s edg;

    ee_pkg::ee_state_e state;
    ee_pkg::ee_state_e next_state;
    ee_pkg::ee_kind_e kind;
    ee_pkg::ee_kind_e next_kind;
    logic [3:0] count;
    logic [3:0] next_count;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [10:0] ptr;
    logic [10:0] next_ptr;
    logic oe_n;
    logic next_oe_n;
    logic data_seen;
    logic next_seen;
    logic wmode;
    logic next_wmode;
    logic mack;
    logic next_mack;
    logic pbuf_we;
    logic pbuf_clr;
    logic wc_go;
    logic tx_load;

    logic busy;
    logic next_busy;
    logic [20:0] timer;
    logic [20:0] next_timer;
    logic [15:0] pvalid;
    logic [15:0] next_pvalid;
    logic mem_we;
    logic [10:0] mem_addr;
    logic [7:0] mem_rd;

    logic [7:0] mem [ee_pkg::MEM_BYTES];
    logic [7:0] pbuf [ee_pkg::PAGE_BYTES];

    // whole-array increment, wraps top address to zero
    function automatic logic [10:0] addr_next(input logic [10:0] a);
        addr_next = a + 11'h001;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    ee_sync u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .pins_i({scl_i, sda_i, wp_i}),
        .pins_o(pin),
        .edges_o(edg)
    );

    // ------------------------------------------------------------
    // protocol engine
    // ------------------------------------------------------------

    // byte read port for the transmitter, follows the pointer
    assign mem_rd = mem[ptr];

    // line changes only follow scl falls or bus conditions
    always_comb begin
        next_state = state;
        next_kind = kind;
        next_count = count;
        next_shift = shift;
        next_ptr = ptr;
        next_oe_n = oe_n;
        next_seen = data_seen;
        next_wmode = wmode;
        next_mack = mack;
        pbuf_we = 1'b0;
        pbuf_clr = 1'b0;
        wc_go = 1'b0;
        tx_load = 1'b0;
        if (edg.start) begin
            // any start, also a repeated one, begins a control byte
            next_state = ee_pkg::ST_RX;
            next_kind = ee_pkg::K_CTRL;
            next_count = 4'h0;
            next_oe_n = 1'b1;
            next_seen = 1'b0;
            next_wmode = 1'b0;
            pbuf_clr = !busy;
        end else if (edg.stop) begin
            // stop ends everything and may start programming
            next_state = ee_pkg::ST_IDLE;
            next_oe_n = 1'b1;
            next_wmode = 1'b0;
            wc_go = wmode && data_seen && !pin.wp;
        end else begin
            case (state)
                ee_pkg::ST_RX: begin
                    if (edg.scl_rise && count != ee_pkg::BYTE_BITS) begin
                        // sample on the rising clock, msb first
                        next_shift = {shift[6:0], pin.sda};
                        next_count = count + 4'h1;
                    end else if (edg.scl_fall && count == ee_pkg::BYTE_BITS) begin
                        next_state = ee_pkg::ST_RXACK;
                        next_count = 4'h0;
                        case (kind)
                            ee_pkg::K_CTRL: begin
                                // code must match and no cycle may run
                                if (shift[ee_pkg::CODE_MSB:ee_pkg::CODE_LSB] == ee_pkg::CTRL_CODE && !busy) begin
                                    next_oe_n = 1'b0;
                                    next_ptr[10:8] = shift[ee_pkg::BLK_MSB:ee_pkg::BLK_LSB];
                                end else begin
                                    next_state = ee_pkg::ST_IDLE;
                                end
                            end
                            ee_pkg::K_ADDR: begin
                                next_oe_n = 1'b0;
                                next_ptr = {ptr[10:8], shift};
                            end
                            ee_pkg::K_WDATA: begin
                                // buffer the byte, wrap within the page
                                next_oe_n = 1'b0;
                                pbuf_we = 1'b1;
                                next_seen = 1'b1;
                                next_ptr = {ptr[10:4], ptr[3:0] + 4'h1};
                            end
                            default: begin
                                next_state = ee_pkg::ST_IDLE;
                            end
                        endcase
                    end
                end
                ee_pkg::ST_RXACK: begin
                    if (edg.scl_fall) begin
                        // end of the ninth clock, release the line, or drive bit 7 of the first byte when a read starts
                        next_oe_n = 1'b1;
                        next_state = ee_pkg::ST_RX;
                        case (kind)
                            ee_pkg::K_CTRL: begin
                                if (shift[ee_pkg::DIR_BIT]) begin
                                    tx_load = 1'b1;
                                end else begin
                                    next_kind = ee_pkg::K_ADDR;
                                    next_wmode = 1'b1;
                                end
                            end
                            ee_pkg::K_ADDR: begin
                                next_kind = ee_pkg::K_WDATA;
                            end
                            default: begin
                                next_kind = kind;
                            end
                        endcase
                    end
                end
                ee_pkg::ST_TX: begin
                    if (edg.scl_rise) begin
                        next_count = count + 4'h1;
                    end else if (edg.scl_fall) begin
                        if (count == ee_pkg::BYTE_BITS) begin
                            next_state = ee_pkg::ST_TXACK;
                            next_count = 4'h0;
                            next_oe_n = 1'b1;
                            next_mack = 1'b0;
                        end else begin
                            // next bit goes out while the clock is low
                            next_shift = {shift[6:0], 1'b0};
                            next_oe_n = shift[6];
                        end
                    end
                end
                ee_pkg::ST_TXACK: begin
                    if (edg.scl_rise) begin
                        next_mack = !pin.sda;
                    end else if (edg.scl_fall) begin
                        if (mack) begin
                            tx_load = 1'b1;
                        end else begin
                            next_state = ee_pkg::ST_IDLE; // line stays released
                        end
                    end
                end
                default: begin
                    next_state = ee_pkg::ST_IDLE;
                    next_oe_n = 1'b1;
                end
            endcase
        end
        if (tx_load) begin
            // fetch the byte and advance across the whole array
            next_state = ee_pkg::ST_TX;
            next_kind = ee_pkg::K_RDATA;
            next_count = 4'h0;
            next_shift = mem_rd;
            next_oe_n = mem_rd[7];
            next_ptr = addr_next(ptr);
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state <= ee_pkg::ST_IDLE;
            kind <= ee_pkg::K_CTRL;
            count <= 4'h0;
            shift <= 8'h00;
            ptr <= ee_pkg::RST_PTR;
            oe_n <= 1'b1;
            data_seen <= 1'b0;
            wmode <= 1'b0;
            mack <= 1'b0;
        end else begin
            state <= next_state;
            kind <= next_kind;
            count <= next_count;
            shift <= next_shift;
            ptr <= next_ptr;
            oe_n <= next_oe_n;
            data_seen <= next_seen;
            wmode <= next_wmode;
            mack <= next_mack;
        end
    end

    // ------------------------------------------------------------
    // self-timed write cycle
    // ------------------------------------------------------------

    // the first sixteen ticks commit the page, the rest only wait out the cycle
    always_comb begin
        next_busy = busy;
        next_timer = timer;
        if (busy) begin
            if (timer == T_LAST) begin
                next_busy = 1'b0;
                next_timer = 21'h000000;
            end else begin
                next_timer = timer + 21'h000001;
            end
        end else if (wc_go) begin
            next_busy = 1'b1;
            next_timer = 21'h000000;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            busy <= 1'b0;
            timer <= 21'h000000;
        end else begin
            busy <= next_busy;
            timer <= next_timer;
        end
    end

    // ------------------------------------------------------------
    // page buffer and array
    // ------------------------------------------------------------

    // valid marks which page slots the commit may copy
    always_comb begin
        next_pvalid = pvalid;
        if (pbuf_clr || (busy && timer == T_LAST)) begin
            next_pvalid = ee_pkg::RST_VALID;
        end else if (pbuf_we) begin
            next_pvalid[ptr[3:0]] = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pvalid <= ee_pkg::RST_VALID;
        end else begin
            pvalid <= next_pvalid;
        end
    end

    // a late wp rise still stops the commit mid-page
    assign mem_we = busy && timer < 21'(ee_pkg::PAGE_BYTES) && pvalid[timer[3:0]] && !pin.wp;
    assign mem_addr = {ptr[10:4], timer[3:0]};

    // storage has no reset, as a nonvolatile array would not
    always_ff @(posedge clock_i) begin
        if (pbuf_we) begin
            pbuf[ptr[3:0]] <= shift;
        end
        if (mem_we) begin
            mem[mem_addr] <= pbuf[timer[3:0]];
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    // open drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_n_o = oe_n;
    assign write_busy_o = busy;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence ctrl_done_s;
        state == ee_pkg::ST_RX && kind == ee_pkg::K_CTRL && edg.scl_fall && count == ee_pkg::BYTE_BITS
            && !edg.start && !edg.stop;
    endsequence

    sequence nack_s;
        state == ee_pkg::ST_TXACK && edg.scl_rise && pin.sda && !edg.start && !edg.stop;
    endsequence

    ctrl_code_a: assert property (ctrl_done_s ##0 (shift[7:4] != ee_pkg::CTRL_CODE) |=> oe_n)
        else $error("foreign control code was acknowledged");

    busy_silent_a: assert property (busy |-> oe_n && state != ee_pkg::ST_TX)
        else $error("device drove sda during write cycle");

    drive_edge_a: assert property ($changed(oe_n) |-> $past(edg.scl_fall || edg.start || edg.stop))
        else $error("sda drive changed while scl high");

    wc_start_a: assert property (edg.stop && wmode && data_seen && !pin.wp && !busy |=> busy && timer == 21'h0)
        else $error("stop after data did not start write cycle");

    wc_end_a: assert property (busy && timer == T_LAST |=> !busy)
        else $error("write cycle overran its time");

    wp_block_a: assert property (pin.wp |-> !mem_we)
        else $error("array written under write protect");

    wp_nostart_a: assert property (edg.stop && pin.wp && !busy |=> !busy)
        else $error("write cycle started under write protect");

    page_wrap_a: assert property (pbuf_we |=> ptr == {$past(ptr[10:4]), 4'($past(ptr[3:0]) + 4'h1)})
        else $error("page pointer left its page");

    read_inc_a: assert property (tx_load |=> ptr == $past(ptr) + 11'h1 && state == ee_pkg::ST_TX)
        else $error("read did not advance pointer");

    nack_release_a: assert property (nack_s |=> oe_n [*2])
        else $error("line not released after master nack");

    no_data_a: assert property (edg.stop && !data_seen && !busy |=> !busy)
        else $error("write cycle started without data");

endmodule
`default_nettype wire

// ===== ee_master.sv
// behavioural two-wire bus master that drives clock and data
`timescale 1ns/1ns
`default_nettype none
module ee_master (
    input wire logic sda_i,
    output var logic scl_o,
    output var logic sda_oe_n_o
);
    // clock stands high between frames, data left to the pull-up
    initial begin
        scl_o = 1'b1;
        sda_oe_n_o = 1'b1;
    end

    // start or repeated start, entered with the clock at either level
    task automatic start_c;
        scl_o = 1'b0;
        #20 sda_oe_n_o = 1'b1;
        #20 scl_o = 1'b1;
        #40 sda_oe_n_o = 1'b0;
        #40 scl_o = 1'b0;
    endtask

    // stop: data rises while the clock is high
    task automatic stop_c;
        scl_o = 1'b0;
        #20 sda_oe_n_o = 1'b0;
        #20 scl_o = 1'b1;
        #40 sda_oe_n_o = 1'b1;
        #40;
    endtask

    // one pulse a bit; data moves only in the low phase, sampled twice in the high phase
    task automatic bit_c(input logic drv_n, output logic s0, output logic s1);
        scl_o = 1'b0;
        #20 sda_oe_n_o = drv_n;
        #20 scl_o = 1'b1;
        #10 s0 = sda_i;
        #25 s1 = sda_i;
        #5;
    endtask

    // byte out msb first, ninth pulse released for the answer
    task automatic send_b(input logic [7:0] b, output logic ack_n);
        logic s0;
        logic s1;
        for (int i = 7; i >= 0; i--) bit_c(b[i], s0, s1);
        bit_c(1'b1, s0, s1);
        ack_n = s0 | s1;
    endtask

    // byte in; low on the ninth pulse asks for more, high ends the read
    task automatic recv_b(input logic ack_n, output logic [7:0] b, output logic steady);
        logic s0;
        logic s1;
        steady = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            bit_c(1'b1, s0, s1);
            b[i] = s0;
            steady = steady & (s0 === s1);
        end
        bit_c(ack_n, s0, s1);
    endtask
endmodule
`default_nettype wire

// ===== ee_slave_test.sv
// self-checking bench for the two-wire eeprom slave
`timescale 1ns/1ns
`default_nettype none
module ee_slave_test;
    // short write cycle keeps polling runs brief
    localparam int WC = 400;
    localparam int LIMIT = 60000;
    localparam int DLY = 1;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic wp_i = 1'b0;
    logic sda_o;
    logic sda_oe_n_o;
    logic write_busy_o;
    logic m_scl;
    logic m_oe_n;
    wire sda;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int run = 0;
    int busy_len = 0;
    logic [7:0] exp_q[$];

    // open-drain wire with pull-up
    assign sda = !sda_oe_n_o ? sda_o : (m_oe_n ? 1'b1 : 1'b0);

    always #2 clock_i = ~clock_i;

    ee_slave #(.WRITE_CYCLES(WC)) u_ee_slave (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .scl_i(m_scl),
        .sda_i(sda),
        .wp_i(wp_i),
        .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n_o),
        .write_busy_o(write_busy_o)
    );

    ee_master u_ee_master (
        .sda_i(sda),
        .scl_o(m_scl),
        .sda_oe_n_o(m_oe_n)
    );

    // length of the last busy run, latched when it ends
    always @(posedge clock_i) begin
        if (write_busy_o === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            busy_len <= run;
            run <= 0;
        end
    end

    // hang guard
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_count++;
            wrap_up;
        end
    end

    // ----------------------------------------
    // compare and report
    // ----------------------------------------
    task automatic bad(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        bad({31'h0, g}, {31'h0, e});
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        bad({24'h0, g}, {24'h0, e});
    endtask
    task automatic chk32(input int g, input int e);
        bad(g, e);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // transfer helpers
    // ----------------------------------------
    // page slot k after 18 bytes from slot 10: the two oldest are overwritten
    function automatic logic [7:0] exp_pg(input int k);
        int i;
        i = (k + 6) % 16;
        if (i < 2) i += 16;
        return 8'h40 + 8'(i);
    endfunction
    task automatic ctrl(input logic [7:0] c, input logic ack_n);
        logic a;
        u_ee_master.start_c;
        u_ee_master.send_b(c, a);
        chk1(a, ack_n);
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] ad, input int n, input logic [7:0] d0);
        logic k;
        ctrl(c, 1'b0);
        u_ee_master.send_b(ad, k);
        chk1(k, 1'b0);
        for (int i = 0; i < n; i++) begin
            u_ee_master.send_b(d0 + 8'(i), k);
            chk1(k, 1'b0);
        end
    endtask
    task automatic rd(input logic [7:0] c);
        logic [7:0] b;
        logic st;
        ctrl(c, 1'b0);
        foreach (exp_q[i]) begin
            u_ee_master.recv_b(i == exp_q.size() - 1, b, st);
            chk8(b, exp_q[i]);
            chk1(st, 1'b1);
        end
        chk1(sda, 1'b1);
        u_ee_master.stop_c;
        exp_q.delete();
    endtask
    task automatic rrd(input logic [7:0] c, input logic [7:0] ad);
        logic k;
        ctrl(c, 1'b0);
        u_ee_master.send_b(ad, k);
        chk1(k, 1'b0);
        rd(c | 8'h01);
        chk1(write_busy_o, 1'b0);
    endtask
    // acknowledge polling right after stop; the first poll falls inside the cycle, a second lands past it
    task automatic poll(input logic [7:0] c);
        logic a;
        chk1(write_busy_o, 1'b1);
        ctrl(c, 1'b1);
        a = 1'b1;
        for (int i = 0; i < 8 && a; i++) begin
            u_ee_master.start_c;
            u_ee_master.send_b(c, a);
        end
        chk1(a, 1'b0);
        u_ee_master.stop_c;
        chk32(busy_len, WC);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_bad_code;
        logic [7:0] c[3] = '{8'h2c, 8'hb6, 8'he7};
        foreach (c[i]) ctrl(c[i], 1'b1);
        u_ee_master.stop_c;
    endtask
    // 18 bytes into page 0x330 from 0x33a: wrap inside the page
    task automatic t_page;
        wr(8'ha6, 8'h3a, 18, 8'h40);
        u_ee_master.stop_c;
        poll(8'ha6);
    endtask
    task automatic t_rand;
        for (int k = 0; k < 15; k++) exp_q.push_back(exp_pg(k));
        rrd(8'ha6, 8'h30);
    endtask
    task automatic t_cur;
        exp_q.push_back(exp_pg(15));
        rd(8'ha7);
    endtask
    task automatic t_wp;
        @(posedge clock_i);
        #DLY wp_i = 1'b1;
        wr(8'ha6, 8'h35, 1, 8'h99);
        u_ee_master.stop_c;
        chk1(write_busy_o, 1'b0);
        exp_q.push_back(exp_pg(5));
        rrd(8'ha6, 8'h35);
        @(posedge clock_i);
        #DLY wp_i = 1'b0;
    endtask
    task automatic t_nodata;
        wr(8'ha6, 8'h30, 0, 8'h00);
        u_ee_master.stop_c;
        chk1(write_busy_o, 1'b0);
    endtask
    // top address of block 7 then address zero: read must wrap
    task automatic t_wrap;
        wr(8'hae, 8'hff, 1, 8'h5a);
        u_ee_master.stop_c;
        poll(8'hae);
        wr(8'ha0, 8'h00, 1, 8'hc3);
        u_ee_master.stop_c;
        poll(8'ha0);
        exp_q = '{8'h5a, 8'hc3};
        rrd(8'hae, 8'hff);
    endtask

    // reset for three clocks, let the synchroniser fill, then run
    initial begin
        repeat (3) @(posedge clock_i);
        #DLY rst_i = 1'b0;
        repeat (4) @(posedge clock_i);
        // master timing is in whole clocks, so this offset keeps every pin move off the edge
        #DLY;
        t_bad_code;
        t_page;
        t_rand;
        t_cur;
        t_wp;
        t_nodata;
        t_wrap;
        wrap_up;
    end
endmodule
`default_nettype wire
